// *** src/uart_channel.v ***
// One serial channel: register bus, baud timing, transmit path, ready and interrupt pins
`timescale 1ns/1ps
`default_nettype none
`include "uart_chan_map.vh"
module uart_channel #(
  parameter FIFO_DEPTH = 128,
  parameter FIFO_AW    = 7
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       osc_in,
  input  wire       cs_n,
  input  wire       ior_n,
  input  wire       iow_n,
  input  wire [2:0] addr,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_n,
  input  wire [7:0] rx_data,
  input  wire [7:0] rx_level,
  input  wire       rx_char,
  output reg        rx_read,
  output reg        tx_out,
  output reg        int_out,
  output reg        rx_ready_n,
  output reg        tx_ready_n
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam SW = 15;
  reg  [SW-1:0] meta_ff;
  reg  [SW-1:0] sync_ff;
  reg           osc_d_ff;
  reg           rd_d_ff;
  reg           wr_d_ff;
  wire          s_osc;
  wire          s_rd;
  wire          s_wr;
  wire [2:0]    s_addr;
  wire [7:0]    s_din;
  wire          rd_start;
  wire          wr_end;
  wire          osc_tick;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      meta_ff  <= {SW{1'b0}};
      sync_ff  <= {SW{1'b0}};
      osc_d_ff <= 1'b0;
      rd_d_ff  <= 1'b0;
      wr_d_ff  <= 1'b0;
    end
    else
    begin
      meta_ff  <= {osc_in, !cs_n & !ior_n, !cs_n & !iow_n, addr, data_in, 1'b0};
      sync_ff  <= meta_ff;
      osc_d_ff <= s_osc;
      rd_d_ff  <= s_rd;
      wr_d_ff  <= s_wr;
    end
  end

  assign s_osc    = sync_ff[14];
  assign s_rd     = sync_ff[13];
  assign s_wr     = sync_ff[12];
  assign s_addr   = sync_ff[11:9];
  assign s_din    = sync_ff[8:1];
  assign rd_start = s_rd & !rd_d_ff;
  // Write takes effect when the strobe ends, data then settled
  assign wr_end   = !s_wr & wr_d_ff;
  assign osc_tick = s_osc & !osc_d_ff;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg  [7:0] ier_ff;
  reg  [7:0] fcr_ff;
  reg  [7:0] lcr_ff;
  reg  [7:0] mcr_ff;
  reg  [7:0] spr_ff;
  reg  [7:0] feature_control_reg_ff;
  reg  [7:0] div_lo_ff;
  reg  [7:0] div_hi_ff;
  reg        tx_flush_ff;
  wire       dlab;
  wire       feat;
  wire       fifo_en;
  wire       block_en;
  wire       wr_thr;

  assign dlab     = lcr_ff[`LCR_DLAB];
  assign feat     = (lcr_ff == `LCR_FEATURE);
  assign fifo_en  = fcr_ff[`FCR_FIFO_EN];
  assign block_en = fifo_en & fcr_ff[`FCR_BLOCK];
  assign wr_thr   = wr_end & (s_addr == `OFS_DATA) & !dlab;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ier_ff      <= `RST_BYTE;
      fcr_ff      <= `RST_BYTE;
      lcr_ff      <= `RST_BYTE;
      mcr_ff      <= `RST_BYTE;
      spr_ff      <= `RST_BYTE;
      feature_control_reg_ff     <= `RST_BYTE;
      div_lo_ff   <= `RST_BYTE;
      div_hi_ff   <= `RST_BYTE;
      tx_flush_ff <= 1'b0;
    end
    else
    begin
      tx_flush_ff <= 1'b0;
      if (wr_end)
      begin
        case (s_addr)
          `OFS_DATA:
            if (dlab)
              div_lo_ff <= s_din;
          `OFS_IER:
            if (feat)
              feature_control_reg_ff <= s_din;
            else if (dlab)
              div_hi_ff <= s_din;
            else
              ier_ff <= s_din;
          `OFS_FCR:
          begin
            fcr_ff      <= {s_din[7:3], 2'b00, s_din[0]};
            tx_flush_ff <= s_din[`FCR_TX_RESET] | (s_din[0] != fcr_ff[0]);
          end
          `OFS_LCR: lcr_ff <= s_din;
          `OFS_MCR: mcr_ff <= s_din;
          `OFS_SPR: spr_ff <= s_din;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud timing and transmit FIFO
  // ----------------------------------------------------------------
  wire             tick16;
  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire [7:0]       fifo_out_data;
  wire [FIFO_AW:0] fifo_count;
  wire             load_shift;
  wire             fifo_full;
  wire             fifo_empty;

  baud_gen u_baud (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .osc_tick  (osc_tick),
    .prescale4 (mcr_ff[`MCR_PRESCALE]),
    .divisor   ({div_hi_ff, div_lo_ff}),
    .tick16    (tick16)
  );

  // Writes to the holding register beyond a full FIFO are dropped
  tx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (tx_flush_ff),
    .in_valid  (wr_thr & !fifo_full),
    .in_ready  (fifo_in_ready),
    .in_data   (s_din),
    .out_valid (fifo_out_valid),
    .out_ready (load_shift),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  assign fifo_empty = !fifo_out_valid;
  // Without FIFO only one byte may wait in the holding register
  assign fifo_full  = fifo_en ? !fifo_in_ready : fifo_out_valid;

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA  = 3'd2;
  localparam ST_PAR   = 3'd3;
  localparam ST_STOP  = 3'd4;

  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg  [7:0] shift_ff;
  reg  [3:0] sub_ff;
  reg  [2:0] bit_ff;
  reg        stop_ff;
  reg        par_ff;
  wire       bit_end;
  wire [2:0] last_bit;
  wire       data_bit;
  wire       par_bit;

  assign load_shift = (state_ff == ST_IDLE) & fifo_out_valid & tick16;
  assign bit_end    = tick16 & (sub_ff == 4'hf);
  assign last_bit   = {1'b1, lcr_ff[1:0]};
  // Line follows the shift and parity updates made on this edge
  assign data_bit   = (bit_end && state_ff == ST_DATA) ? shift_ff[1] : shift_ff[0];
  assign par_bit    = (bit_end && state_ff == ST_DATA) ? par_ff ^ shift_ff[0] : par_ff;

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (load_shift) nxt_state = ST_START;
      ST_START: if (bit_end) nxt_state = ST_DATA;
      ST_DATA:
        if (bit_end && bit_ff == last_bit)
          nxt_state = lcr_ff[3] ? ST_PAR : ST_STOP;
      ST_PAR:   if (bit_end) nxt_state = ST_STOP;
      ST_STOP:
        if (bit_end && (stop_ff || !lcr_ff[2]))
          nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      sub_ff   <= 4'h0;
      bit_ff   <= 3'd0;
      stop_ff  <= 1'b0;
      par_ff   <= 1'b0;
      tx_out   <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      if (load_shift)
      begin
        shift_ff <= fifo_out_data;
        sub_ff   <= 4'h0;
        bit_ff   <= 3'd0;
        stop_ff  <= 1'b0;
        par_ff   <= !lcr_ff[4];
      end
      else if (tick16 && state_ff != ST_IDLE)
        sub_ff <= sub_ff + 4'h1;
      if (bit_end && state_ff == ST_DATA)
      begin
        par_ff   <= par_ff ^ shift_ff[0];
        shift_ff <= {1'b0, shift_ff[7:1]};
        bit_ff   <= bit_ff + 3'd1;
      end
      if (bit_end && state_ff == ST_STOP)
        stop_ff <= 1'b1;
      case (nxt_state)
        ST_START: tx_out <= 1'b0;
        ST_DATA:  tx_out <= data_bit;
        ST_PAR:   tx_out <= lcr_ff[5] ? !lcr_ff[4] : par_bit;
        default:  tx_out <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trigger levels and receive timeout
  // ----------------------------------------------------------------
  reg  [9:0] tmo_ff;
  reg  [3:0] tmo_sub_ff;
  reg        tmo_flag_ff;
  wire [7:0] rx_trig;
  wire [7:0] tx_trig;
  wire [9:0] tmo_limit;
  wire       tx_empty_all;

  function [7:0] trig_sel;
    input [1:0] code;
    input       is_rx;
    begin
      case (code)
        2'd0:    trig_sel = 8'h08;
        2'd1:    trig_sel = 8'h10;
        2'd2:    trig_sel = is_rx ? 8'h38 : 8'h20;
        default: trig_sel = is_rx ? 8'h3c : 8'h38;
      endcase
    end
  endfunction

  assign rx_trig      = trig_sel(fcr_ff[7:6], 1'b1);
  assign tx_trig      = trig_sel(fcr_ff[5:4], 1'b0);
  // Four character lengths plus twelve bits, in whole bit times
  assign tmo_limit    = {6'h00, lcr_ff[1:0], 2'h0} + 10'h014 + `TMO_EXTRA;
  assign tx_empty_all = fifo_empty & (state_ff == ST_IDLE);

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tmo_ff      <= 10'h000;
      tmo_sub_ff  <= 4'h0;
      tmo_flag_ff <= 1'b0;
    end
    else if (rx_char || rd_start || rx_level == 8'h00)
    begin
      tmo_ff      <= 10'h000;
      tmo_sub_ff  <= 4'h0;
      tmo_flag_ff <= 1'b0;
    end
    else if (tick16 && !tmo_flag_ff)
    begin
      // Own bit-time count; the shifter's only runs while sending
      tmo_sub_ff <= tmo_sub_ff + 4'h1;
      if (tmo_sub_ff == 4'hf)
      begin
        if (tmo_ff == tmo_limit - 10'h001)
          tmo_flag_ff <= 1'b1;
        tmo_ff <= tmo_ff + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and ready pins
  // ----------------------------------------------------------------
  reg tx_int;
  reg rx_int;

  always @*
  begin
    if (!fifo_en)
      tx_int = feature_control_reg_ff[`FEATURE_CONTROL_REG_TX_SEL] ? tx_empty_all : fifo_empty;
    else if (feature_control_reg_ff[`FEATURE_CONTROL_REG_TX_SEL])
      tx_int = ({1'b0, fifo_count} < {1'b0, tx_trig}) | tx_empty_all;
    else
      tx_int = ({1'b0, fifo_count} <= {1'b0, tx_trig}) | fifo_empty;
    if (!fifo_en)
      rx_int = (rx_level != 8'h00);
    else
      rx_int = (rx_level >= rx_trig) | tmo_flag_ff;
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      int_out    <= 1'b0;
      rx_ready_n <= 1'b1;
      tx_ready_n <= 1'b0;
    end
    else
    begin
      int_out <= (tx_int & ier_ff[`IER_TX]) | (rx_int & ier_ff[`IER_RX]);
      if (!block_en)
      begin
        rx_ready_n <= (rx_level == 8'h00);
        tx_ready_n <= !fifo_empty;
      end
      else
      begin
        if (rx_level == 8'h00)
          rx_ready_n <= 1'b1;
        else if (rx_level >= rx_trig || tmo_flag_ff)
          rx_ready_n <= 1'b0;
        tx_ready_n <= fifo_full;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  reg [7:0] rd_val;

  always @*
  begin
    case (s_addr)
      `OFS_DATA: rd_val = dlab ? div_lo_ff : rx_data;
      `OFS_IER:
        if (feat)
          rd_val = feature_control_reg_ff;
        else
          rd_val = dlab ? div_hi_ff : ier_ff;
      `OFS_FCR:
        if (rx_int && ier_ff[`IER_RX])
          rd_val = tmo_flag_ff ? `ISR_TIMEOUT : `ISR_RX;
        else if (tx_int && ier_ff[`IER_TX])
          rd_val = `ISR_TX;
        else
          rd_val = `ISR_NONE;
      `OFS_LCR: rd_val = lcr_ff;
      `OFS_MCR: rd_val = mcr_ff;
      `OFS_LSR: rd_val = {1'b0, tx_empty_all, fifo_empty, 4'h0, rx_level != 8'h00};
      `OFS_SPR: rd_val = spr_ff;
      default:  rd_val = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
      rx_read   <= 1'b0;
    end
    else
    begin
      data_oe_n <= !s_rd;
      rx_read   <= rd_start & (s_addr == `OFS_DATA) & !dlab;
      if (rd_start)
        data_out <= rd_val;
    end
  end
endmodule // uart_channel
`default_nettype wire

// *** inc/uart_chan_map.vh ***
// Register offsets, field positions, reset values and counts of one serial channel
`ifndef UART_CHAN_MAP_VH
`define UART_CHAN_MAP_VH
`define OFS_DATA      3'h0
`define OFS_IER       3'h1
`define OFS_FCR       3'h2
`define OFS_LCR       3'h3
`define OFS_MCR       3'h4
`define OFS_LSR       3'h5
`define OFS_MSR       3'h6
`define OFS_SPR       3'h7
`define LCR_FEATURE   8'hbf
`define LCR_DLAB      7
`define MCR_PRESCALE  7
`define FCR_FIFO_EN   0
`define FCR_RX_RESET  1
`define FCR_TX_RESET  2
`define FCR_BLOCK     3
`define FEATURE_CONTROL_REG_TX_SEL   3
`define IER_RX        0
`define IER_TX        1
`define RST_BYTE      8'h00
`define ISR_NONE      8'h01
`define ISR_TX        8'h02
`define ISR_RX        8'h04
`define ISR_TIMEOUT   8'h0c
`define TICKS_PER_BIT 5'h10
`define TMO_EXTRA     10'h00c
`endif

// *** src/tx_fifo.v ***
// Transmit byte FIFO with valid/ready on both sides and a fill count
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 128,
  parameter AW    = 7
) (
  input  wire             core_clk,
  input  wire             nrst,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign count     = count_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  always @(posedge core_clk)
  begin
    if (!nrst || flush)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule // tx_fifo
`default_nettype wire

// *** src/baud_gen.v ***
// Prescaler and 16-bit divisor producing the 16x sampling enable
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        osc_tick,
  input  wire        prescale4,
  input  wire [15:0] divisor,
  output reg         tick16
);
  reg  [1:0]  pre_ff;
  reg  [15:0] div_ff;
  wire        pre_tick;

  // Divide by one or four ahead of the divisor
  assign pre_tick = osc_tick & (!prescale4 | (pre_ff == 2'h3));

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pre_ff <= 2'h0;
      div_ff <= 16'h0000;
      tick16 <= 1'b0;
    end
    else
    begin
      tick16 <= 1'b0;
      if (osc_tick)
        pre_ff <= prescale4 ? pre_ff + 2'h1 : 2'h0;
      // Divisor zero leaves the generator stopped
      if (pre_tick && divisor != 16'h0000)
      begin
        if (div_ff >= divisor - 16'h0001)
        begin
          div_ff <= 16'h0000;
          tick16 <= 1'b1;
        end
        else
          div_ff <= div_ff + 16'h0001;
      end
    end
  end
endmodule // baud_gen
`default_nettype wire

// *** testbench/uart_channel_assertions.sv ***
// Pin-level assertions for one serial channel
`timescale 1ns/1ps
`default_nettype none
module uart_channel_checks (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic       ior_n,
  input wire logic       iow_n,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       rx_read,
  input wire logic [7:0] rx_level,
  input wire logic       tx_out,
  input wire logic       int_out,
  input wire logic       rx_ready_n,
  input wire logic       tx_ready_n
);
  logic [5:0] gap_ff;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // ------------------------------
  // Cycles since tx_out last moved
  // ------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      gap_ff <= 6'h3f;
    else if ($changed(tx_out))
      gap_ff <= 6'h00;
    else if (gap_ff != 6'h3f)
      gap_ff <= gap_ff + 6'h01;
  end
  // ------------------------------
  // Properties
  // ------------------------------
  reset_state_a: assert property (disable iff (1'b0) !nrst |=> tx_out && !int_out
    && rx_ready_n && !tx_ready_n && data_oe_n) else $error("bad pin state after reset");
  read_drive_a: assert property ($fell(data_oe_n) |-> $past(!cs_n && !ior_n, 2))
    else $error("data bus driven without a read");
  read_release_a: assert property ($rose(ior_n) |-> ##[1:5] data_oe_n)
    else $error("data bus not released after read");
  read_hold_a: assert property (!data_oe_n && $past(!data_oe_n) |-> $stable(data_out))
    else $error("read data moved while driven");
  rx_read_pulse_a: assert property (rx_read |-> $fell(data_oe_n) ##1 !rx_read)
    else $error("receive read pulse misplaced");
  bit_hold_a: assert property ($changed(tx_out) |-> gap_ff >= 6'h10)
    else $error("serial bit too short");
  tx_ready_rise_a: assert property ($rose(tx_ready_n)
    |-> $past(!iow_n, 4) || $past(!iow_n, 6) || $past(!iow_n, 8))
    else $error("tx_ready_n rose without a write");
  rx_ready_fall_a: assert property ($fell(rx_ready_n)
    |-> $past(rx_level) != 8'h00 || $past(rx_level, 2) != 8'h00)
    else $error("rx_ready_n fell with no data");
  rx_ready_rise_a: assert property ($rose(rx_ready_n)
    |-> $past(rx_level) == 8'h00 || $past(rx_level, 2) == 8'h00)
    else $error("rx_ready_n rose with data left");
endmodule // uart_channel_checks
bind uart_channel uart_channel_checks uart_channel_checks_inst (
  .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n),
  .data_out(data_out), .data_oe_n(data_oe_n), .rx_read(rx_read), .rx_level(rx_level),
  .tx_out(tx_out), .int_out(int_out), .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n));
`default_nettype wire

// *** testbench/host_model.sv ***
// Host processor model on the asynchronous register bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       core_clk,
  output var  logic       cs_n,
  output var  logic       ior_n,
  output var  logic       iow_n,
  output var  logic [2:0] addr,
  output var  logic [7:0] data_in,
  input  wire logic [7:0] data_out
);
  initial
  begin
    cs_n = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
  end
  // Strobe low 5 clocks, data held 3 more, then 4 idle
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    begin
      @(posedge core_clk);
      cs_n <= 1'b0;
      ior_n <= wr;
      iow_n <= !wr;
      addr <= a;
      data_in <= wr ? d : ~data_in;
      repeat (5) @(posedge core_clk);
      q = data_out;
      cs_n <= 1'b1;
      ior_n <= 1'b1;
      iow_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      data_in <= ~data_in;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule // host_model
`default_nettype wire

// *** testbench/uart_channel_tb.sv ***
// Self-checking bench for one serial channel
`timescale 1ns/1ps
`default_nettype none
`include "uart_chan_map.vh"
module uart_channel_tb;
  localparam int OSC_CLKS = 4;
  localparam int BITC = 16 * OSC_CLKS;
  // Osc rate / prescale / (16 * bit rate)
  localparam logic [15:0] DIV = 16'h0001;
  logic            core_clk = 1'b0;
  logic            nrst     = 1'b0;
  logic            osc_in   = 1'b0;
  logic            osc_run  = 1'b0;
  logic [7:0]      rx_level = 8'h00;
  logic [7:0]      q;
  logic [11:0]     n;
  int              i;
  int              n_fail = 0;
  int              checked = 0;
  wire logic       cs_n, ior_n, iow_n, data_oe_n, tx_out, int_out, rx_ready_n, tx_ready_n;
  wire logic [2:0] addr;
  wire logic [7:0] data_in, data_out;
  uart_channel #(.FIFO_DEPTH(8), .FIFO_AW(3)) uart_channel_inst (
    .core_clk(core_clk), .nrst(nrst), .osc_in(osc_in), .cs_n(cs_n), .ior_n(ior_n),
    .iow_n(iow_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .rx_data(8'h00), .rx_level(rx_level), .rx_char(1'b0),
    .rx_read(), .tx_out(tx_out), .int_out(int_out), .rx_ready_n(rx_ready_n),
    .tx_ready_n(tx_ready_n));
  host_model host_model_inst (
    .core_clk(core_clk), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n), .addr(addr),
    .data_in(data_in), .data_out(data_out));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    forever
    begin
      repeat (OSC_CLKS / 2) @(posedge core_clk);
      if (osc_run)
        osc_in <= ~osc_in;
    end
  end
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_model_inst.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a);
    host_model_inst.access(1'b0, a, 8'h00, q);
  endtask
  task automatic pins(input logic [2:0] e);
    begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check({9'h000, int_out, rx_ready_n, tx_ready_n}, {9'h000, e});
      @(posedge core_clk);
    end
  endtask
  task automatic wait_start;
    for (int k = 0; k < 5000 && tx_out !== 1'b0; k++)
      @(posedge core_clk);
  endtask
  task automatic low_len;
    begin
      n = 12'h000;
      wait_start();
      while (tx_out === 1'b0 && n < 12'hfff)
      begin
        @(posedge core_clk);
        n = n + 12'h001;
      end
    end
  endtask
  // Bits sampled mid-cell, start bit in bit 0
  task automatic frame(input int nb, input logic [11:0] e);
    logic [11:0] got;
    begin
      got = 12'h000;
      wait_start();
      repeat (BITC / 2) @(posedge core_clk);
      for (int k = 0; k < nb; k++)
      begin
        if (k > 0)
          repeat (BITC) @(posedge core_clk);
        got[k] = tx_out;
      end
      check(got, e);
    end
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    pins(3'b010);
    wr(`OFS_SPR, 8'h5a);
    rd(`OFS_SPR);
    check({4'h0, q}, 12'h05a);
    osc_run <= 1'b1;
    wr(`OFS_IER, 8'h01);
    rx_level <= 8'h01;
    pins(3'b100);
    rx_level <= 8'h00;
    pins(3'b010);
    wr(`OFS_FCR, 8'h09);
    rx_level <= 8'h07;
    pins(3'b010);
    rx_level <= 8'h08;
    pins(3'b100);
    rx_level <= 8'h03;
    pins(3'b000);
    rx_level <= 8'h00;
    pins(3'b010);
    wr(`OFS_IER, 8'h02);
    wr(`OFS_LCR, 8'h03);
    pins(3'b110);
    // Burst of trigger size, then one write too many
    for (i = 0; i < 9; i++)
    begin
      wr(`OFS_DATA, {i[3:0], ~i[3:0]});
      if (i == 6)
        pins(3'b110);
      if (i == 7)
        pins(3'b111);
    end
    rd(`OFS_LSR);
    check({4'h0, q & 8'h60}, 12'h000);
    wr(`OFS_LCR, 8'h83);
    wr(`OFS_IER, DIV[15:8]);
    wr(`OFS_DATA, DIV[7:0]);
    for (i = 0; i < 8; i++)
      frame(10, {3'b001, i[3:0], ~i[3:0], 1'b0});
    repeat (BITC) @(posedge core_clk);
    rd(`OFS_LSR);
    check({4'h0, q & 8'h60}, 12'h060);
    pins(3'b110);
    wr(`OFS_FCR, 8'h00);
    wr(`OFS_DATA, 8'h00);
    wr(`OFS_LCR, 8'h1b);
    wr(`OFS_DATA, 8'ha5);
    wr(`OFS_DATA, 8'h5a);
    pins(3'b011);
    rd(`OFS_LSR);
    check({4'h0, q & 8'h60}, 12'h000);
    wr(`OFS_LCR, 8'h9b);
    wr(`OFS_DATA, DIV[7:0]);
    frame(11, {2'b01, ^8'ha5, 8'ha5, 1'b0});
    repeat (BITC) @(posedge core_clk);
    pins(3'b110);
    rd(`OFS_LSR);
    check({4'h0, q & 8'h60}, 12'h060);
    wr(`OFS_LCR, 8'h04);
    wr(`OFS_DATA, 8'h13);
    frame(8, {4'h0, 2'b11, 5'h13, 1'b0});
    wr(`OFS_FCR, 8'h01);
    wr(`OFS_MCR, 8'h80);
    wr(`OFS_DATA, 8'h1e);
    wr(`OFS_DATA, 8'h1e);
    low_len();
    low_len();
    check(n, 12'(8 * BITC));
    wr(`OFS_MCR, 8'h00);
    wr(`OFS_DATA, 8'h1e);
    wr(`OFS_DATA, 8'h1e);
    low_len();
    low_len();
    check(n, 12'(2 * BITC));
    wr(`OFS_FCR, 8'h09);
    wr(`OFS_IER, 8'h01);
    rx_level <= 8'h03;
    pins(3'b010);
    // Data left below trigger: timeout after 32 bit times
    repeat (2100) @(posedge core_clk);
    pins(3'b100);
    rd(`OFS_FCR);
    check({4'h0, q}, {4'h0, `ISR_TIMEOUT});
    rd(`OFS_DATA);
    check({4'h0, q}, 12'h000);
    rx_level <= 8'h00;
    pins(3'b010);
    end_of_test();
  end
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_fail = n_fail + 1;
    end_of_test();
  end
endmodule // uart_channel_tb
`default_nettype wire
